// [interrupt_transfer_routing_params.svh]
// Offsets, field positions, reset values and state budgets of the router
`ifndef INTERRUPT_TRANSFER_ROUTING_PARAMS_SVH
`define INTERRUPT_TRANSFER_ROUTING_PARAMS_SVH

// Register offsets (byte addresses)
`define ITR_OFS_ACT_EN    8'h00
`define ITR_OFS_INT_SEL   8'h04
`define ITR_OFS_FLAG      8'h08
`define ITR_OFS_PRIO      8'h0c
`define ITR_OFS_STATUS    8'h10
`define ITR_OFS_MASK      8'h14
`define ITR_OFS_ROUTE     8'h18

// Event status bit positions
`define ITR_EV_DTC_END    0
`define ITR_EV_DMA_END    1
`define ITR_EV_FETCH      2
`define ITR_EV_W          3

// Reset values
`define ITR_RST_ZERO      32'h0000_0000

// State budgets
`define ITR_JUDGE_PERI    8'h00
`define ITR_JUDGE_PIN     8'h01
`define ITR_CMP_PERI      8'h02
`define ITR_CMP_PIN       8'h03
`define ITR_EXC_BASE      8'h05

`endif

// [interrupt_transfer_routing_pkg.sv]
// Types shared by the interrupt transfer router
package interrupt_transfer_routing_pkg;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_COMPARE = 2'b01,
    ST_WAIT    = 2'b10,
    ST_EXCEPT  = 2'b11
  } resp_state_t;

endpackage

// [interrupt_transfer_routing.sv]
// Interrupt source router between transfer engines and the CPU
//
// Behaviour
// - Judgment step: pin sources take one state, peripheral sources none.
// - Least response is 10 states for peripheral, 12 for pin sources.
// - Exception phase takes 5 states plus save and vector access states.
// - Acceptance waits while the CPU finishes a running sequence.
// - DMA mask is global enable and OR of channel enable with selection.
// - CPU request of a source is blocked while its activation enable is set.
// - Activation enable clears on transfer end with select or zero count.
// - Source flag clears on transfer end without qualifier, or on DMA end.
// - With select set, transfer end clears enable, keeps flag, interrupts CPU.
// - DMA routed sources mask both CPU request and transfer activation.
// - DMA controller clears the source flag when it transfers.
// - With select clear and count nonzero, transfer end clears flag and keeps enable.
// - With select clear and zero count, enable clears and CPU interrupted.
// - Unrouted source with enable clear goes to CPU; handler clears flag.
// - CPU request only when priority exceeds current mask level.
// - Pin flag also clears after a transfer triggered by that pin.
//
// Decided for this implementation: strobed register access and the placing of the registers.

`include "interrupt_transfer_routing_params.svh"
module interrupt_transfer_routing #(
  parameter int N_SRC   = 8,
  parameter int N_PIN   = 2,
  parameter int M_SR    = 1,
  parameter int M_PC    = 1,
  parameter int M_VEC   = 1,
  parameter int SRC_W   = $clog2(N_SRC)
) (
  input  wire logic                   sys_clk,
  input  wire logic                   rst_b,
  // Register port
  input  wire logic [7:0]             reg_addr,
  input  wire logic [31:0]            reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [31:0]            reg_rdata,
  output logic                        irq,
  // Sources
  input  wire logic [N_PIN-1:0]       irq_pin_b,
  input  wire logic [N_SRC-N_PIN-1:0] periph_req,
  // DMA routing
  input  wire logic                   dma_global_enable,
  input  wire logic                   dma_channel0_enable,
  input  wire logic                   dma_channel1_enable,
  input  wire logic                   dma_channel2_enable,
  input  wire logic                   dma_channel3_enable,
  input  wire logic [SRC_W-1:0]       dma_channel0_select,
  input  wire logic [SRC_W-1:0]       dma_channel1_select,
  input  wire logic [SRC_W-1:0]       dma_channel2_select,
  input  wire logic [SRC_W-1:0]       dma_channel3_select,
  output logic      [N_SRC-1:0]       dma_req,
  input  wire logic                   dma_end,
  input  wire logic [SRC_W-1:0]       dma_end_src,
  // Block transfer controller
  output logic      [N_SRC-1:0]       xfer_req,
  input  wire logic                   xfer_end,
  input  wire logic [SRC_W-1:0]       xfer_end_src,
  input  wire logic                   xfer_count_zero,
  // CPU side
  input  wire logic [3:0]             cpu_mask_level,
  input  wire logic                   cpu_busy,
  output logic                        cpu_irq_req,
  output logic      [SRC_W-1:0]       cpu_irq_src,
  output logic      [3:0]             cpu_irq_level,
  output logic                        handler_fetch_start
);

  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] EXC_STATES =
    8'(`ITR_EXC_BASE + M_SR + M_PC + M_VEC);
  localparam logic [7:0] PRE_PERI = 8'(`ITR_JUDGE_PERI + `ITR_CMP_PERI);
  localparam logic [7:0] PRE_PIN  = 8'(`ITR_JUDGE_PIN + `ITR_CMP_PIN);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  logic [N_SRC-1:0]           xfer_activation_enable_q;
  logic [N_SRC-1:0]           xfer_interrupt_select_q;
  logic [N_SRC-1:0]           flag_q;
  logic [N_SRC-1:0]           flag_d;
  logic [4*N_SRC-1:0]         prio_q;
  logic [`ITR_EV_W-1:0]       status_q;
  logic [`ITR_EV_W-1:0]       mask_q;
  logic [N_PIN-1:0]           pin_s1_q;
  logic [N_PIN-1:0]           pin_s2_q;
  logic [N_PIN-1:0]           pin_s3_q;
  logic [N_PIN-1:0]           pin_level_q;
  logic [N_PIN-1:0]           pin_fall;
  logic [N_SRC-1:0]           src_event;
  logic [N_SRC-1:0]           dma_mask;
  logic [N_SRC-1:0]           xfer_hit;
  logic [N_SRC-1:0]           dma_hit;
  logic [N_SRC-1:0]           act_clr;
  logic [N_SRC-1:0]           flag_clr;
  logic [N_SRC-1:0]           sw_flag_clr;
  logic [N_SRC-1:0]           cpu_elig;
  logic                       activation_clear_qualifier;
  logic                       best_valid;
  logic [SRC_W-1:0]           best_src;
  logic [3:0]                 best_prio;
  logic                       sel_still;
  logic [`ITR_EV_W-1:0]       ev;
  logic                       wr_act;
  logic                       wr_sel;
  logic                       wr_flag;
  logic                       wr_prio;
  logic                       wr_mask;
  logic                       rd_status;
  logic [31:0]                rdata_d;
  logic [7:0]                 cnt_q;
  logic                       fetch_q;
  logic [SRC_W-1:0]           src_q;
  logic [3:0]                 lvl_q;
  interrupt_transfer_routing_pkg::resp_state_t state_q;

  ////////////////////////////////////////////////////////////////////////////
  // Pin sources: three stages, change taken once stages two and three agree

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1_q    <= '1;
      pin_s2_q    <= '1;
      pin_s3_q    <= '1;
      pin_level_q <= '1;
    end else begin
      pin_s1_q <= irq_pin_b;
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      for (int i = 0; i < N_PIN; i++) begin
        if (pin_s2_q[i] == pin_s3_q[i]) begin
          pin_level_q[i] <= pin_s3_q[i];
        end
      end
    end
  end

  // Falling edge requests; level sense is not offered here
  assign pin_fall  = pin_level_q & ~pin_s3_q & ~pin_s2_q;
  assign src_event = {periph_req, pin_fall};

  ////////////////////////////////////////////////////////////////////////////
  // Routing masks and clear conditions

  always_comb begin
    for (int s = 0; s < N_SRC; s++) begin
      dma_mask[s] = dma_global_enable &
        ((dma_channel0_enable & (dma_channel0_select == SRC_W'(s))) |
         (dma_channel1_enable & (dma_channel1_select == SRC_W'(s))) |
         (dma_channel2_enable & (dma_channel2_select == SRC_W'(s))) |
         (dma_channel3_enable & (dma_channel3_select == SRC_W'(s))));
      xfer_hit[s] = xfer_end & (xfer_end_src == SRC_W'(s)) &
                    xfer_activation_enable_q[s];
      dma_hit[s]  = dma_end & (dma_end_src == SRC_W'(s));
    end
  end

  // Qualifier is the ending source's select or a zero count
  assign activation_clear_qualifier =
    xfer_interrupt_select_q[xfer_end_src] | xfer_count_zero;
  always_comb begin
    for (int s = 0; s < N_SRC; s++) begin
      act_clr[s]  = xfer_hit[s] & activation_clear_qualifier;
      // Flag kept when the qualifier holds so the CPU sees the request
      flag_clr[s] = (xfer_hit[s] & ~activation_clear_qualifier) |
                    dma_hit[s] | sw_flag_clr[s];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register write decode

  always_comb begin
    wr_act    = 1'b0;
    wr_sel    = 1'b0;
    wr_flag   = 1'b0;
    wr_prio   = 1'b0;
    wr_mask   = 1'b0;
    rd_status = 1'b0;
    if (reg_wr && reg_addr == `ITR_OFS_ACT_EN) begin
      wr_act = 1'b1;
    end else if (reg_wr && reg_addr == `ITR_OFS_INT_SEL) begin
      wr_sel = 1'b1;
    end else if (reg_wr && reg_addr == `ITR_OFS_FLAG) begin
      wr_flag = 1'b1;
    end else if (reg_wr && reg_addr == `ITR_OFS_PRIO) begin
      wr_prio = 1'b1;
    end else if (reg_wr && reg_addr == `ITR_OFS_MASK) begin
      wr_mask = 1'b1;
    end else if (reg_rd && reg_addr == `ITR_OFS_STATUS) begin
      rd_status = 1'b1;
    end
  end

  // Write one clears a flag
  assign sw_flag_clr = wr_flag ? reg_wdata[N_SRC-1:0] : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Activation enable and interrupt select

  // Hardware clear beats a same-cycle software write to avoid re-arming
  // a source whose block just ended
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_activation_enable_q <= N_SRC'(`ITR_RST_ZERO);
    end else begin
      xfer_activation_enable_q <=
        (wr_act ? reg_wdata[N_SRC-1:0] : xfer_activation_enable_q) &
        ~act_clr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      xfer_interrupt_select_q <= N_SRC'(`ITR_RST_ZERO);
      prio_q                  <= (4*N_SRC)'(`ITR_RST_ZERO);
      mask_q                  <= `ITR_EV_W'(`ITR_RST_ZERO);
    end else begin
      if (wr_sel) begin
        xfer_interrupt_select_q <= reg_wdata[N_SRC-1:0];
      end
      if (wr_prio) begin
        prio_q <= reg_wdata[4*N_SRC-1:0];
      end
      if (wr_mask) begin
        mask_q <= reg_wdata[`ITR_EV_W-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source flags: a new request wins over any clear

  assign flag_d = src_event | (flag_q & ~flag_clr);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flag_q <= N_SRC'(`ITR_RST_ZERO);
    end else begin
      flag_q <= flag_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Engine requests, one judgment state through a register

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dma_req  <= N_SRC'(`ITR_RST_ZERO);
      xfer_req <= N_SRC'(`ITR_RST_ZERO);
    end else begin
      dma_req  <= flag_q & dma_mask;
      xfer_req <= flag_q & xfer_activation_enable_q & ~dma_mask;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // CPU selection: highest level above mask, lowest index on a tie

  assign cpu_elig = flag_q & ~xfer_activation_enable_q & ~dma_mask;

  always_comb begin
    best_valid = 1'b0;
    best_src   = '0;
    best_prio  = cpu_mask_level;
    for (int s = 0; s < N_SRC; s++) begin
      if (cpu_elig[s] && prio_q[4*s +: 4] > best_prio) begin
        best_valid = 1'b1;
        best_src   = SRC_W'(s);
        best_prio  = prio_q[4*s +: 4];
      end
    end
  end

  assign sel_still = cpu_elig[src_q] && (lvl_q > cpu_mask_level);

  ////////////////////////////////////////////////////////////////////////////
  // Response sequencer

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= interrupt_transfer_routing_pkg::ST_IDLE;
      cnt_q   <= 8'h00;
      src_q   <= '0;
      lvl_q   <= 4'h0;
      fetch_q <= 1'b0;
    end else begin
      fetch_q <= 1'b0;
      case (state_q)
        interrupt_transfer_routing_pkg::ST_IDLE: begin
          if (best_valid) begin
            src_q   <= best_src;
            lvl_q   <= best_prio;
            state_q <= interrupt_transfer_routing_pkg::ST_COMPARE;
            if (int'(best_src) < N_PIN) begin
              cnt_q <= PRE_PIN - 8'h02;
            end else begin
              cnt_q <= PRE_PERI - 8'h02;
            end
          end
        end
        interrupt_transfer_routing_pkg::ST_COMPARE: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else if (!sel_still) begin
            state_q <= interrupt_transfer_routing_pkg::ST_IDLE;
          end else if (cpu_busy) begin
            state_q <= interrupt_transfer_routing_pkg::ST_WAIT;
          end else begin
            state_q <= interrupt_transfer_routing_pkg::ST_EXCEPT;
            cnt_q   <= EXC_STATES - 8'h01;
          end
        end
        interrupt_transfer_routing_pkg::ST_WAIT: begin
          if (!cpu_busy) begin
            state_q <= interrupt_transfer_routing_pkg::ST_EXCEPT;
            cnt_q   <= EXC_STATES - 8'h01;
          end
        end
        interrupt_transfer_routing_pkg::ST_EXCEPT: begin
          if (cnt_q != 8'h00) begin
            cnt_q <= cnt_q - 8'h01;
          end else begin
            fetch_q <= 1'b1;
            state_q <= interrupt_transfer_routing_pkg::ST_IDLE;
          end
        end
        default: begin
          state_q <= interrupt_transfer_routing_pkg::ST_IDLE;
        end
      endcase
    end
  end

  assign cpu_irq_req = (state_q == interrupt_transfer_routing_pkg::ST_WAIT) |
                       (state_q == interrupt_transfer_routing_pkg::ST_EXCEPT);
  assign cpu_irq_src         = src_q;
  assign cpu_irq_level       = lvl_q;
  assign handler_fetch_start = fetch_q;

  ////////////////////////////////////////////////////////////////////////////
  // Event status, cleared by reading; a new event wins over the read

  always_comb begin
    ev = '0;
    ev[`ITR_EV_DTC_END] = |act_clr;
    ev[`ITR_EV_DMA_END] = |dma_hit;
    ev[`ITR_EV_FETCH]   = fetch_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= `ITR_EV_W'(`ITR_RST_ZERO);
    end else begin
      status_q <= ev | (rd_status ? '0 : status_q);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_q & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the strobe; unmapped reads give zero

  always_comb begin
    rdata_d = 32'h0000_0000;
    if (reg_addr == `ITR_OFS_ACT_EN) begin
      rdata_d = 32'(xfer_activation_enable_q);
    end else if (reg_addr == `ITR_OFS_INT_SEL) begin
      rdata_d = 32'(xfer_interrupt_select_q);
    end else if (reg_addr == `ITR_OFS_FLAG) begin
      rdata_d = 32'(flag_q);
    end else if (reg_addr == `ITR_OFS_PRIO) begin
      rdata_d = 32'(prio_q);
    end else if (reg_addr == `ITR_OFS_STATUS) begin
      rdata_d = 32'(status_q);
    end else if (reg_addr == `ITR_OFS_MASK) begin
      rdata_d = 32'(mask_q);
    end else if (reg_addr == `ITR_OFS_ROUTE) begin
      rdata_d = 32'(dma_mask);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata <= `ITR_RST_ZERO;
    end else begin
      reg_rdata <= reg_rd ? rdata_d : `ITR_RST_ZERO;
    end
  end

endmodule

// [interrupt_transfer_routing_checker.sv]
// Port level assertions of the interrupt transfer router
module interrupt_transfer_routing_checker #(
  parameter int N_SRC = 8,
  parameter int M_SR  = 1,
  parameter int M_PC  = 1,
  parameter int M_VEC = 1,
  parameter int SRC_W = 3
) (
  input wire logic             sys_clk,
  input wire logic             rst_b,
  input wire logic             reg_rd,
  input wire logic [31:0]      reg_rdata,
  input wire logic             dma_global_enable,
  input wire logic [N_SRC-1:0] dma_req,
  input wire logic             dma_end,
  input wire logic [SRC_W-1:0] dma_end_src,
  input wire logic [N_SRC-1:0] xfer_req,
  input wire logic             xfer_end,
  input wire logic [SRC_W-1:0] xfer_end_src,
  input wire logic [3:0]       cpu_mask_level,
  input wire logic             cpu_irq_req,
  input wire logic [SRC_W-1:0] cpu_irq_src,
  input wire logic [3:0]       cpu_irq_level,
  input wire logic             handler_fetch_start
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam int EXC = 5 + M_SR + M_PC + M_VEC;
  logic [7:0] run_q;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  // Cycles the CPU request has stood, counted up to the fetch
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_q <= 8'h00;
    end else begin
      run_q <= cpu_irq_req ? run_q + 8'h01 : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  sequence s_xfer_done;
    xfer_end && xfer_req[xfer_end_src];
  endsequence
  sequence s_dma_done;
    dma_end && dma_req[dma_end_src];
  endsequence
  sequence s_accept;
    $rose(cpu_irq_req);
  endsequence

  ////////////////////////////////////////////////////////////////////////
  AST_ROUTE_SPLIT: assert property (!(|(dma_req & xfer_req)))
    else $error("one source requests both engines");
  AST_DMA_OFF: assert property (!$past(dma_global_enable) |-> !(|dma_req))
    else $error("dma request without global enable");
  AST_EXC_LEN: assert property (handler_fetch_start |-> run_q >= EXC)
    else $error("handler fetch before exception phase ended");
  AST_FETCH_END: assert property ($fell(cpu_irq_req) |-> handler_fetch_start)
    else $error("cpu request ended without handler fetch");
  AST_FETCH_ONE: assert property (handler_fetch_start |=> !handler_fetch_start)
    else $error("handler fetch pulse too long");
  AST_LEVEL: assert property (s_accept |-> cpu_irq_level > cpu_mask_level)
    else $error("request accepted at or below mask level");
  AST_BLOCK: assert property (s_accept |->
    !xfer_req[cpu_irq_src] && !dma_req[cpu_irq_src])
    else $error("cpu took a source owned by an engine");
  AST_DMA_CLEAR: assert property (s_dma_done |->
    ##2 !dma_req[$past(dma_end_src, 2)])
    else $error("dma request stands after dma end");
  AST_XFER_CLEAR: assert property (s_xfer_done |->
    ##2 !xfer_req[$past(xfer_end_src, 2)])
    else $error("transfer request stands after transfer end");
  AST_RDATA_IDLE: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside the read answer cycle");
endmodule

bind interrupt_transfer_routing interrupt_transfer_routing_checker #(
  .N_SRC(N_SRC), .M_SR(M_SR), .M_PC(M_PC), .M_VEC(M_VEC), .SRC_W(SRC_W)
) chk_u (
  .sys_clk, .rst_b, .reg_rd, .reg_rdata, .dma_global_enable, .dma_req,
  .dma_end, .dma_end_src, .xfer_req, .xfer_end, .xfer_end_src,
  .cpu_mask_level, .cpu_irq_req, .cpu_irq_src, .cpu_irq_level,
  .handler_fetch_start
);

// [transfer_partner_model.sv]
// Far side model: transfer engines and the CPU mask level
module engine_lane #(
  parameter int N_SRC = 8,
  parameter int SRC_W = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [N_SRC-1:0] req,
  input  wire logic [3:0]       lag,
  output logic                  done,
  output logic [SRC_W-1:0]      done_src
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]       wait_q;
  logic [3:0]       cool_q;
  logic             busy_q;
  logic [SRC_W-1:0] src_q;
  // Inverse outside the pulse so a stale source never looks valid
  assign done_src = done ? src_q : ~src_q;
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      {done, busy_q, wait_q, cool_q, src_q} <= '0;
    end else begin
      done <= 1'b0;
      if (cool_q != 4'h0) begin
        cool_q <= cool_q - 4'h1;
      end else if (busy_q && wait_q != 4'h0) begin
        wait_q <= wait_q - 4'h1;
      end else if (busy_q) begin
        done   <= 1'b1;
        busy_q <= 1'b0;
        cool_q <= 4'h5; // Let the request fall before looking again
      end else if (|req) begin
        busy_q <= 1'b1;
        wait_q <= lag;
        for (int i = N_SRC - 1; i >= 0; i--) begin
          if (req[i]) src_q <= i[SRC_W-1:0];
        end
      end
    end
  end
endmodule

module transfer_partner_model (
  input  wire logic       sys_clk,
  input  wire logic       rst_b,
  input  wire logic [7:0] dma_req,
  input  wire logic [7:0] xfer_req,
  input  wire logic [3:0] lag,
  input  wire logic       zero_in,
  input  wire logic [3:0] base_level,
  input  wire logic       rte,
  input  wire logic       cpu_irq_req,
  input  wire logic [3:0] cpu_irq_level,
  output logic            dma_end,
  output logic [2:0]      dma_end_src,
  output logic            xfer_end,
  output logic [2:0]      xfer_end_src,
  output logic            xfer_count_zero,
  output logic [3:0]      cpu_mask_level
);
  timeunit 1ns;
  timeprecision 1ps;
  engine_lane dma_u (.sys_clk, .rst_b, .req(dma_req), .lag,
    .done(dma_end), .done_src(dma_end_src));
  engine_lane xfer_u (.sys_clk, .rst_b, .req(xfer_req), .lag,
    .done(xfer_end), .done_src(xfer_end_src));
  // Counter state is only meaningful beside the end pulse
  assign xfer_count_zero = xfer_end ? zero_in : ~zero_in;
  // CPU takes the accepted level as its mask until the handler returns
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cpu_mask_level <= 4'h0;
    end else if (cpu_irq_req) begin
      cpu_mask_level <= cpu_irq_level;
    end else if (rte) begin
      cpu_mask_level <= base_level;
    end
  end
endmodule

// [interrupt_transfer_routing_tb_top.sv]
// Self-checking bench of the interrupt transfer router
`include "interrupt_transfer_routing_params.svh"
module interrupt_transfer_routing_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic             sys_clk = 1'b0;
  logic             rst_b = 1'b0;
  logic [7:0]       reg_addr = 8'h00;
  logic [31:0]      reg_wdata = 32'h0;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [1:0]       irq_pin_b = 2'h3;
  logic [5:0]       periph_req = 6'h00;
  logic             dma_global_enable = 1'b0;
  logic [3:0]       ch_en = 4'h0;
  logic [3:0][2:0]  ch_sel = 12'h000;
  logic             cpu_busy = 1'b0;
  logic [3:0]       lag = 4'h0;
  logic             zero_in = 1'b0;
  logic [3:0]       base_level = 4'h0;
  logic             rte = 1'b0;
  logic [31:0]      reg_rdata;
  logic             irq;
  logic [7:0]       dma_req;
  logic [7:0]       xfer_req;
  logic             dma_end;
  logic [2:0]       dma_end_src;
  logic             xfer_end;
  logic [2:0]       xfer_end_src;
  logic             xfer_count_zero;
  logic [3:0]       cpu_mask_level;
  logic             cpu_irq_req;
  logic [2:0]       cpu_irq_src;
  logic [3:0]       cpu_irq_level;
  logic             handler_fetch_start;
  int               seed = 50;
  int               fail_count = 0;
  int               n_tests = 0;

  always #2.5 sys_clk = ~sys_clk;

  interrupt_transfer_routing dut_u (
    .sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .irq, .irq_pin_b, .periph_req, .dma_global_enable,
    .dma_channel0_enable(ch_en[0]), .dma_channel1_enable(ch_en[1]),
    .dma_channel2_enable(ch_en[2]), .dma_channel3_enable(ch_en[3]),
    .dma_channel0_select(ch_sel[0]), .dma_channel1_select(ch_sel[1]),
    .dma_channel2_select(ch_sel[2]), .dma_channel3_select(ch_sel[3]),
    .dma_req, .dma_end, .dma_end_src, .xfer_req, .xfer_end, .xfer_end_src,
    .xfer_count_zero, .cpu_mask_level, .cpu_busy, .cpu_irq_req,
    .cpu_irq_src, .cpu_irq_level, .handler_fetch_start);
  transfer_partner_model part_u (
    .sys_clk, .rst_b, .dma_req, .xfer_req, .lag, .zero_in, .base_level,
    .rte, .cpu_irq_req, .cpu_irq_level, .dma_end, .dma_end_src, .xfer_end,
    .xfer_end_src, .xfer_count_zero, .cpu_mask_level);

  ////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
    @(posedge sys_clk);
  endtask
  task automatic pulse(input int b);
    @(posedge sys_clk);
    periph_req <= 6'h01 << b;
    @(posedge sys_clk);
    periph_req <= 6'h00;
  endtask
  // Cycles until the handler fetch; a required one that never comes ends
  task automatic wait_fetch(input int lim, input bit must, output int n);
    n = 0;
    while (n < lim && handler_fetch_start !== 1'b1) begin
      @(posedge sys_clk);
      #1;
      n++;
    end
    if (must && handler_fetch_start !== 1'b1) begin
      check(32'h0, 32'h1);
      tally_and_finish();
    end
    @(posedge sys_clk);
  endtask
  task automatic set_base(input logic [3:0] l);
    @(posedge sys_clk);
    base_level <= l;
    rte        <= 1'b1;
    @(posedge sys_clk);
    rte <= 1'b0;
  endtask
  task automatic handler(input int s, input logic [3:0] l);
    wr(`ITR_OFS_FLAG, 32'h1 << s);
    set_base(l);
  endtask
  // Expected {enable kept, cpu interrupted, flag kept} after one transfer
  function automatic logic [2:0] mode_exp(input logic sel, input logic z);
    return {!(sel | z), sel | z, sel | z};
  endfunction

  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    logic [2:0]  e;
    int          n;
    repeat (3) @(posedge sys_clk);
    rst_b <= 1'b1;
    for (int a = 0; a <= 28; a += 4) begin
      rd_chk(a[7:0], 32'h0);
    end
    d = $random(seed);
    wr(`ITR_OFS_INT_SEL, d);
    rd_chk(`ITR_OFS_INT_SEL, d & 32'hff);
    wr(`ITR_OFS_MASK, d);
    rd_chk(`ITR_OFS_MASK, d & 32'h7);
    wr(`ITR_OFS_INT_SEL, 32'h0);
    wr(`ITR_OFS_MASK, 32'h0);
    wr(`ITR_OFS_PRIO, 32'h8765_4321);
    $display("Registers done");
    pulse(0);
    wait_fetch(40, 1'b1, n);
    check(n, 32'ha);
    check(cpu_irq_src, 32'h2);
    check(cpu_irq_level, 32'h3);
    handler(2, 4'h3);
    pulse(0);
    wait_fetch(30, 1'b0, n);
    check(n, 32'h1e);
    set_base(4'h2);
    wait_fetch(40, 1'b1, n);
    handler(2, 4'h0);
    @(posedge sys_clk);
    cpu_busy <= 1'b1;
    pulse(0);
    wait_fetch(24, 1'b0, n);
    check(n, 32'h18);
    cpu_busy <= 1'b0;
    wait_fetch(40, 1'b1, n);
    handler(2, 4'h0);
    $display("CPU path done");
    for (int m = 0; m < 3; m++) begin
      e = mode_exp(m[1], m[0]);
      zero_in <= m[0];
      lag <= 4'($random(seed) & 32'h3);
      wr(`ITR_OFS_INT_SEL, {28'h0, m[1], 3'h0});
      wr(`ITR_OFS_ACT_EN, 32'h8);
      pulse(1);
      wait_fetch(40, e[1], n);
      check(n < 40, e[1]);
      rd_chk(`ITR_OFS_ACT_EN, {28'h0, e[2], 3'h0});
      rd_chk(`ITR_OFS_FLAG, {28'h0, e[0], 3'h0});
      if (e[1]) handler(3, 4'h0);
    end
    $display("Transfer modes done");
    for (int c = 0; c < 4; c++) begin
      d = $random(seed) & 32'h7;
      ch_sel[c] <= d[2:0];
      ch_en <= 4'h1 << c;
      dma_global_enable <= 1'b1;
      rd_chk(`ITR_OFS_ROUTE, 32'h1 << d[2:0]);
    end
    ch_sel[1] <= 3'h4;
    ch_en <= 4'h2;
    wr(`ITR_OFS_ACT_EN, 32'h10);
    pulse(2);
    wait_fetch(30, 1'b0, n);
    check(n, 32'h1e);
    rd_chk(`ITR_OFS_FLAG, 32'h0);
    wr(`ITR_OFS_ROUTE, 32'h0);
    rd_chk(`ITR_OFS_ROUTE, 32'h10);
    dma_global_enable <= 1'b0;
    rd_chk(`ITR_OFS_ROUTE, 32'h0);
    wr(`ITR_OFS_ACT_EN, 32'h0);
    $display("DMA routing done");
    @(posedge sys_clk);
    irq_pin_b <= 2'h2;
    wait_fetch(40, 1'b1, n);
    check(n >= 12 && n <= 18, 32'h1);
    check(cpu_irq_src, 32'h0);
    irq_pin_b <= 2'h3;
    handler(0, 4'h0);
    check(irq, 32'h0);
    wr(`ITR_OFS_MASK, 32'h7);
    repeat (2) @(posedge sys_clk);
    #1;
    check(irq, 32'h1);
    rd_chk(`ITR_OFS_STATUS, 32'h7);
    repeat (2) @(posedge sys_clk);
    #1;
    check(irq, 32'h0);
    rd_chk(`ITR_OFS_STATUS, 32'h0);
    $display("Pin and status done");
    tally_and_finish();
  end
endmodule
